// file: hw/ssc_burst_ctr.sv
// Four-beat burst counter with linear or interleaved order
`timescale 1ns/1ns
`default_nettype none
module ssc_burst_ctr (
   input wire logic clock,
   input wire logic resetn,
   ssc_burst_if.ctr bif
);
   import ssc_pkg::*;
   logic [SSC_BURST_W-1:0] start_r, start_nxt, cnt_r, cnt_nxt, cnt_inc;

   always_comb begin
      start_nxt = start_r;
      cnt_nxt = cnt_r;
      cnt_inc = cnt_r + SSC_CNT_STEP;
      if (bif.load) begin
         start_nxt = bif.start;
         cnt_nxt = SSC_CNT_RST;
      end else if (bif.advance) begin
         cnt_nxt = cnt_inc;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         start_r <= SSC_CNT_RST;
         cnt_r <= SSC_CNT_RST;
      end else begin
         start_r <= start_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Interleaved flips bits of the start, linear adds and wraps
   assign bif.offset_next = bif.order ? (start_r ^ cnt_inc) : (start_r + cnt_inc);
   assign bif.cnt = cnt_r;
endmodule : ssc_burst_ctr
`default_nettype wire

// file: hw/ssc_burst_if.sv
// Link between the core and its burst counter
`timescale 1ns/1ns
`default_nettype none
interface ssc_burst_if;
   import ssc_pkg::*;
   logic load;
   logic advance;
   logic order;
   logic [SSC_BURST_W-1:0] start;
   logic [SSC_BURST_W-1:0] offset_next;
   logic [SSC_BURST_W-1:0] cnt;
   modport ctr (input load, input advance, input order, input start, output offset_next, output cnt);
   modport core (output load, output advance, output order, output start, input offset_next, input cnt);
endinterface : ssc_burst_if
`default_nettype wire

// file: hw/ssc_core.sv
// Pipelined synchronous burst SRAM: selects, burst control, registered data paths
`timescale 1ns/1ns
`default_nettype none
module ssc_core #(
   parameter int ADDR_W = ssc_pkg::SSC_ADDR_W
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read_not_write,
   input wire logic select_low_a,
   input wire logic select_low_b,
   input wire logic select_high,
   input wire logic advance_or_load,
   input wire logic clock_suspend_n,
   input wire logic [ssc_pkg::SSC_LANES-1:0] byte_write_n,
   input wire logic burst_order_select,
   input wire logic output_enable_n,
   input wire logic [ssc_pkg::SSC_BUS_W-1:0] data_in,
   output logic [ssc_pkg::SSC_BUS_W-1:0] data_out,
   output logic data_oe
);
   import ssc_pkg::*;

   logic ce, sel, load, desel, adv;
   logic burst_act_r, burst_act_nxt, burst_rd_r, burst_rd_nxt;
   logic [ADDR_W-1:0] base_r, base_nxt;
   logic s1_valid_r, s1_valid_nxt, s1_read_r, s1_read_nxt;
   logic [ADDR_W-1:0] s1_addr_r, s1_addr_nxt;
   logic [SSC_LANES-1:0] s1_bw_r, s1_bw_nxt;
   logic s2_valid_r, s2_valid_nxt, s2_read_r, s2_read_nxt;
   logic [ADDR_W-1:0] s2_addr_r, s2_addr_nxt;
   logic [SSC_LANES-1:0] s2_bw_r, s2_bw_nxt;
   logic rd_valid_r, rd_valid_nxt, wr_pend_r, wr_pend_nxt;
   logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
   logic [SSC_BUS_W-1:0] wr_mask_r, wr_mask_nxt, din_r, din_nxt, dout_r, dout_nxt, mem_word;
   logic [SSC_BUS_W-1:0] mem [2**ADDR_W];

   ssc_burst_if bif ();

   ssc_burst_ctr u_ctr (
      .clock(clock),
      .resetn(resetn),
      .bif(bif)
   );

   // Byte lane k is data bits 8k..8k+7 plus parity bit k
   function automatic logic [SSC_BUS_W-1:0] lane_mask(input logic [SSC_LANES-1:0] bw_n);
      logic [SSC_BUS_W-1:0] m;
      m = '0;
      for (int k = 0; k < SSC_LANES; k++) begin
         m[k*SSC_BYTE_W +: SSC_BYTE_W] = {SSC_BYTE_W{~bw_n[k]}};
         m[SSC_PAR_LSB + k] = ~bw_n[k];
      end
      return m;
   endfunction : lane_mask

   assign ce = ~clock_suspend_n;
   assign sel = ~select_low_a & ~select_low_b & select_high;
   assign load = ce & ~advance_or_load & sel;
   assign desel = ce & ~advance_or_load & ~sel;
   assign adv = ce & advance_or_load & burst_act_r;

   assign bif.load = load;
   assign bif.advance = adv;
   assign bif.order = burst_order_select;
   assign bif.start = address[SSC_BURST_W-1:0];

   // Read of the array with bypass of a write still waiting to land
   always_comb begin
      mem_word = mem[s2_addr_r];
      if (wr_pend_r && wr_addr_r == s2_addr_r) begin
         mem_word = (mem_word & ~wr_mask_r) | (din_r & wr_mask_r);
      end
   end

   always_comb begin
      burst_act_nxt = burst_act_r;
      burst_rd_nxt = burst_rd_r;
      base_nxt = base_r;
      s1_valid_nxt = s1_valid_r;
      s1_read_nxt = s1_read_r;
      s1_addr_nxt = s1_addr_r;
      s1_bw_nxt = s1_bw_r;
      s2_valid_nxt = s2_valid_r;
      s2_read_nxt = s2_read_r;
      s2_addr_nxt = s2_addr_r;
      s2_bw_nxt = s2_bw_r;
      rd_valid_nxt = rd_valid_r;
      wr_pend_nxt = wr_pend_r;
      wr_addr_nxt = wr_addr_r;
      wr_mask_nxt = wr_mask_r;
      din_nxt = din_r;
      dout_nxt = dout_r;
      if (ce) begin
         s1_valid_nxt = load | adv;
         s1_bw_nxt = byte_write_n;
         if (load) begin
            burst_act_nxt = 1'b1;
            burst_rd_nxt = read_not_write;
            base_nxt = address;
            s1_read_nxt = read_not_write;
            s1_addr_nxt = address;
         end else if (adv) begin
            s1_read_nxt = burst_rd_r;
            s1_addr_nxt = {base_r[ADDR_W-1:SSC_BURST_W], bif.offset_next};
         end else if (desel) begin
            burst_act_nxt = 1'b0;
         end
         s2_valid_nxt = s1_valid_r;
         s2_read_nxt = s1_read_r;
         s2_addr_nxt = s1_addr_r;
         s2_bw_nxt = s1_bw_r;
         // Third stage: data moves two cycles after its address
         rd_valid_nxt = s2_valid_r & s2_read_r;
         wr_pend_nxt = s2_valid_r & ~s2_read_r;
         if (s2_valid_r && s2_read_r) begin
            dout_nxt = mem_word;
         end
         if (s2_valid_r && !s2_read_r) begin
            din_nxt = data_in;
            wr_addr_nxt = s2_addr_r;
            wr_mask_nxt = lane_mask(s2_bw_r);
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         burst_act_r <= 1'b0;
         burst_rd_r <= 1'b0;
         base_r <= '0;
         s1_valid_r <= 1'b0;
         s1_read_r <= 1'b0;
         s1_addr_r <= '0;
         s1_bw_r <= '1;
         s2_valid_r <= 1'b0;
         s2_read_r <= 1'b0;
         s2_addr_r <= '0;
         s2_bw_r <= '1;
         rd_valid_r <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         wr_mask_r <= '0;
         din_r <= '0;
         dout_r <= '0;
      end else begin
         burst_act_r <= burst_act_nxt;
         burst_rd_r <= burst_rd_nxt;
         base_r <= base_nxt;
         s1_valid_r <= s1_valid_nxt;
         s1_read_r <= s1_read_nxt;
         s1_addr_r <= s1_addr_nxt;
         s1_bw_r <= s1_bw_nxt;
         s2_valid_r <= s2_valid_nxt;
         s2_read_r <= s2_read_nxt;
         s2_addr_r <= s2_addr_nxt;
         s2_bw_r <= s2_bw_nxt;
         rd_valid_r <= rd_valid_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_mask_r <= wr_mask_nxt;
         din_r <= din_nxt;
         dout_r <= dout_nxt;
      end
   end

   // Array takes the captured write one enabled edge after capture
   always_ff @(posedge clock) begin
      if (ce && wr_pend_r) begin
         mem[wr_addr_r] <= (mem[wr_addr_r] & ~wr_mask_r) | (din_r & wr_mask_r);
      end
   end

   assign data_out = dout_r;
   assign data_oe = rd_valid_r & ~output_enable_n;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence rd_load_s;
      load && read_not_write ##1 ce ##1 ce;
   endsequence
   sequence wr_load_s;
      load && !read_not_write ##1 ce ##1 ce;
   endsequence
   sequence desel_s;
      desel ##1 ce ##1 ce;
   endsequence

   bus_release_a: assert property (desel_s |=> !rd_valid_r && !data_oe)
      else $error("data bus still driven two cycles after deselect");
   read_latency_a: assert property (rd_load_s |=> rd_valid_r)
      else $error("read data not valid two cycles after load");
   write_latency_a: assert property (wr_load_s |=> wr_pend_r && !rd_valid_r && din_r == $past(data_in))
      else $error("write data not captured two cycles after load");
   suspend_hold_a: assert property (!ce |=> $stable(dout_r) && $stable(rd_valid_r) && $stable(s1_addr_r))
      else $error("state changed on a suspended edge");
   oe_release_a: assert property (output_enable_n |-> !data_oe)
      else $error("data driven while output enable is high");
   select_all_a: assert property (ce && !advance_or_load && (select_low_a || select_low_b || !select_high)
      |=> !s1_valid_r)
      else $error("operation started without all three selects true");
   load_addr_a: assert property (load |=> s1_addr_r == $past(address) && s1_valid_r)
      else $error("loaded address does not match sampled address");
   linear_step_a: assert property (adv && !burst_order_select
      |=> s1_addr_r[1:0] == $past(s1_addr_r[1:0]) + SSC_CNT_STEP)
      else $error("linear burst did not step by one");
   interleave_step_a: assert property (adv && burst_order_select
      |=> s1_addr_r[1] == ($past(s1_addr_r[1]) ^ $past(bif.cnt[0])) && s1_addr_r[0] != $past(s1_addr_r[0]))
      else $error("interleaved burst took a wrong step");
   // The flag only moves on an enabled edge, so the step is checked against the edge before
   drive_form_a: assert property (rd_valid_r && !output_enable_n |-> data_oe ##1
      (!$past(ce) || rd_valid_r == ($past(s2_valid_r) && $past(s2_read_r))))
      else $error("drive enable does not follow read-valid flag");
endmodule : ssc_core
`default_nettype wire

// file: hw/ssc_pkg.sv
// Shared widths and field positions for the synchronous select/output SRAM core
package ssc_pkg;
   localparam int SSC_DATA_W = 32;
   localparam int SSC_PAR_W = 4;
   localparam int SSC_BUS_W = SSC_DATA_W + SSC_PAR_W;
   localparam int SSC_BYTE_W = 8;
   localparam int SSC_LANES = 4;
   localparam int SSC_ADDR_W = 17;
   localparam int SSC_BURST_W = 2;
   localparam int SSC_PAR_LSB = 32;
   localparam logic [SSC_BURST_W-1:0] SSC_CNT_RST = 2'h0;
   localparam logic [SSC_BURST_W-1:0] SSC_CNT_STEP = 2'h1;
endpackage : ssc_pkg

// file: test/ssc_ctrl_model.sv
// Memory controller model that drives the SRAM core pins
`timescale 1ns/1ns
`default_nettype none
module ssc_ctrl_model (
   input wire logic clock,
   input wire logic resetn,
   output logic [5:0] address,
   output logic read_not_write,
   output logic select_low_a,
   output logic select_low_b,
   output logic select_high,
   output logic advance_or_load,
   output logic clock_suspend_n,
   output logic [ssc_pkg::SSC_LANES-1:0] byte_write_n,
   output logic burst_order_select,
   output logic output_enable_n,
   output logic [ssc_pkg::SSC_BUS_W-1:0] data_in
);
   import ssc_pkg::*;
   logic [SSC_BUS_W-1:0] wd_cur = '0;
   logic [SSC_BUS_W-1:0] wd_pend = '0;
   logic wr_pend = 1'b0;
   logic burst_wr = 1'b0;
   logic sel;
   assign sel = !select_low_a && !select_low_b && select_high;
   initial begin
      {address, read_not_write, select_low_a, select_low_b, select_high} = '0;
      {advance_or_load, clock_suspend_n, output_enable_n, data_in} = '0;
      byte_write_n = 4'hF;
   end
   task automatic set_order(input logic o);
      burst_order_select <= o;
   endtask : set_order
   task automatic issue(input logic [5:0] a, input logic rnw, input logic [2:0] s, input logic adv,
      input logic sus, input logic oe_n, input logic [3:0] bw, input logic [SSC_BUS_W-1:0] d);
      @(posedge clock);
      address <= a;
      read_not_write <= rnw;
      {select_low_a, select_low_b, select_high} <= s;
      advance_or_load <= adv;
      clock_suspend_n <= sus;
      output_enable_n <= oe_n;
      byte_write_n <= bw;
      wd_cur <= d;
   endtask : issue
   // Write data goes out two taken edges after its address; the bus is scrambled otherwise
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_pend <= 1'b0;
         burst_wr <= 1'b0;
      end else if (!clock_suspend_n) begin
         data_in <= wr_pend ? wd_pend : ~data_in;
         wr_pend <= advance_or_load ? burst_wr : (sel && !read_not_write);
         wd_pend <= wd_cur;
         if (!advance_or_load) begin
            burst_wr <= sel && !read_not_write;
         end
      end
   end
endmodule : ssc_ctrl_model
`default_nettype wire

// file: test/sync_sram_select_output_ctrl_tb.sv
// Self-checking bench for the SRAM core
`timescale 1ns/1ns
`default_nettype none
module sync_sram_select_output_ctrl_tb;
   import ssc_pkg::*;
   typedef struct packed {logic v; logic rd; logic [5:0] a; logic [3:0] bw;} ssc_op_s;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] address;
   logic read_not_write, select_low_a, select_low_b, select_high, advance_or_load;
   logic clock_suspend_n, burst_order_select, output_enable_n, data_oe;
   logic [3:0] byte_write_n;
   logic [SSC_BUS_W-1:0] data_in, data_out, exp_d;
   logic [SSC_BUS_W-1:0] mem [0:63];
   logic exp_v = 1'b0;
   logic act = 1'b0;
   logic brd;
   logic [5:0] base;
   logic [1:0] cnt;
   ssc_op_s p1, p2, cur;
   int fails = 0;
   int check_count = 0;
   always #20 clock = ~clock;
   ssc_core #(.ADDR_W(6)) u_dut (.clock, .resetn, .address, .read_not_write, .select_low_a, .select_low_b,
      .select_high, .advance_or_load, .clock_suspend_n, .byte_write_n, .burst_order_select, .output_enable_n,
      .data_in, .data_out, .data_oe);
   ssc_ctrl_model u_ctrl (.clock, .resetn, .address, .read_not_write, .select_low_a, .select_low_b,
      .select_high, .advance_or_load, .clock_suspend_n, .byte_write_n, .burst_order_select,
      .output_enable_n, .data_in);
   function automatic logic [5:0] burst_addr(input logic [5:0] b, input logic [1:0] c, input logic o);
      return {b[5:2], o ? b[1:0] ^ c : b[1:0] + c};
   endfunction : burst_addr
   function automatic logic [35:0] merge(input logic [35:0] m, input logic [35:0] d, input logic [3:0] bw);
      for (int k = 0; k < 4; k++) begin
         if (!bw[k]) begin
            m[8*k+:8] = d[8*k+:8];
            m[32+k] = d[32+k];
         end
      end
      return m;
   endfunction : merge
   // Reference pipeline, stepped only on taken edges
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {p1, p2, exp_v, act} = '0;
      end else if (!clock_suspend_n) begin
         cur = '0;
         if (!advance_or_load) begin
            act = !select_low_a && !select_low_b && select_high;
            {base, cnt, brd} = {address, 2'h0, read_not_write};
            cur = '{act, brd, address, byte_write_n};
         end else if (act) begin
            cnt = cnt + 2'h1;
            cur = '{1'b1, brd, burst_addr(base, cnt, burst_order_select), byte_write_n};
         end
         exp_v = p2.v && p2.rd;
         if (exp_v) exp_d = mem[p2.a];
         if (p2.v && !p2.rd) mem[p2.a] = merge(mem[p2.a], data_in, p2.bw);
         p2 = p1;
         p1 = cur;
      end
   end
   task automatic check(input string what, input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : check
   always @(negedge clock) begin
      if (resetn) begin
         check("data_oe", {35'h0, exp_v && !output_enable_n}, {35'h0, data_oe});
         if (exp_v && !output_enable_n) check("data_out", exp_d, data_out);
      end
   end
   task automatic op(input logic [5:0] a, input logic rnw, input logic [2:0] s, input logic adv,
      input logic sus, input logic oe_n);
      u_ctrl.issue(a, rnw, s, adv, sus, oe_n, 4'h0, 36'({$urandom, $urandom}));
   endtask : op
   task automatic rand_ops(input int n);
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         r = $urandom;
         u_ctrl.issue(r[5:0], r[6], r[9:7] == 3'h0 ? r[12:10] : 3'b001, r[13] & r[14], r[15] & r[16],
            r[18] & r[19], r[23:20] & r[27:24], 36'({$urandom, $urandom}));
      end
   endtask : rand_ops
   task automatic corners;
      logic [2:0] dsel [3] = '{3'b101, 3'b011, 3'b000};
      op(6'h07, 1, 3'b001, 0, 0, 0);
      repeat (5) op(6'h3F, 0, 3'b001, 1, 0, 0);
      op(6'h0A, 0, 3'b001, 0, 0, 0);
      repeat (3) op(6'h00, 1, 3'b001, 1, 0, 0);
      op(6'h0A, 1, 3'b001, 0, 0, 0);
      repeat (3) op(6'h00, 0, 3'b001, 1, 0, 0);
      foreach (dsel[k]) begin
         op(6'(k), 1, 3'b001, 0, 0, 0);
         op(6'h01, 1, dsel[k], 0, 0, 0);
         op(6'h02, 0, 3'b001, 1, 0, 0);
      end
      u_ctrl.issue(6'h05, 0, 3'b001, 0, 0, 0, 4'hA, 36'h9_1234_5678);
      op(6'h05, 1, 3'b001, 0, 0, 0);
      op(6'h05, 1, 3'b001, 0, 1, 0);
      op(6'h05, 1, 3'b001, 1, 1, 1);
      op(6'h05, 1, 3'b001, 1, 1, 0);
      repeat (4) op(6'h00, 1, 3'b000, 0, 0, 0);
   endtask : corners
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   initial begin
      #(5000 * 40);
      fails++;
      final_report();
   end
   initial begin
      void'($urandom(32'h47749474));
      for (int o = 0; o < 2; o++) begin
         @(posedge clock);
         resetn <= 1'b0;
         u_ctrl.set_order(o[0]);
         repeat (3) @(posedge clock);
         resetn <= 1'b1;
         if (o == 0) for (int i = 0; i < 64; i++) op(6'(i), 0, 3'b001, 0, 0, 0);
         rand_ops(400);
         corners();
         $display("test order %0d done", o);
      end
      final_report();
   end
endmodule : sync_sram_select_output_ctrl_tb
`default_nettype wire
